// >>> pkg/irq_resp_params.svh
// Constants for the four-level interrupt response block.
`ifndef IRQ_RESP_PARAMS_SVH
`define IRQ_RESP_PARAMS_SVH
`define OSC_PER_MCYCLE      12
`define MCYCLE_CNT_W        4
`define PHASE_LATCH         4'd9
`define VECTOR_CALL_CYCLES  2'd2
`define NUM_SRC             6
`define SRC_EXT0            0
`define SRC_TMR0            1
`define SRC_EXT1            2
`define SRC_TMR1            3
`define SRC_SER             4
`define SRC_TMR2            5
`define VEC_BASE            16'h0003
`define VEC_STRIDE          16'h0008
`define ADDR_CTRL           12'h000
`define ADDR_ENABLE         12'h004
`define ADDR_PRIO_LO        12'h008
`define ADDR_PRIO_HI        12'h00c
`define ADDR_STATUS         12'h010
`define ADDR_INT_STAT       12'h014
`define ADDR_INT_MASK       12'h018
`define ADDR_VECTOR         12'h01c
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10
`endif

// >>> pkg/irq_resp_pkg.sv
// Types shared by the four-level interrupt response block.
package irq_resp_pkg;
    typedef logic [1:0] level_type;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_CALL1 = 3'b010,
        ST_CALL2 = 3'b100
    } resp_state_type;
endpackage

// >>> hw/irq_resp.sv
// Interrupt acceptance, priority and vector-call logic with an AXI4-Lite register port.
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "irq_resp_params.svh"
module irq_resp #(
    parameter int NSRC = `NUM_SRC
) (
    input  wire logic                 CLK,
    input  wire logic                 RSTN,
    input  wire logic                 EXT_IRQ0_PIN_N,
    input  wire logic                 EXT_IRQ1_PIN_N,
    input  wire logic [NSRC-1:0]      PERIPH_REQ,
    input  wire logic                 INSTR_LAST_CYCLE,
    input  wire logic                 INSTR_IS_RETURN_FROM_INTERRUPT,
    input  wire logic                 INSTR_IS_RET,
    input  wire logic                 INSTR_IS_IRQ_REG_ACCESS,
    input  wire logic [15:0]          PC_IN,
    output logic                      PUSH_VALID,
    output logic [7:0]                PUSH_DATA,
    output logic                      POP_REQ,
    output logic                      PC_LOAD,
    output logic [15:0]               PC_VECTOR,
    output logic                      CORE_HOLD,
    output logic [3:0]                PHASE,
    output logic                      IRQ,
    input  wire logic [11:0]          S_AXI_AWADDR,
    input  wire logic                 S_AXI_AWVALID,
    output logic                      S_AXI_AWREADY,
    input  wire logic [31:0]          S_AXI_WDATA,
    input  wire logic [3:0]           S_AXI_WSTRB,
    input  wire logic                 S_AXI_WVALID,
    output logic                      S_AXI_WREADY,
    output logic [1:0]                S_AXI_BRESP,
    output logic                      S_AXI_BVALID,
    input  wire logic                 S_AXI_BREADY,
    input  wire logic [11:0]          S_AXI_ARADDR,
    input  wire logic                 S_AXI_ARVALID,
    output logic                      S_AXI_ARREADY,
    output logic [31:0]               S_AXI_RDATA,
    output logic [1:0]                S_AXI_RRESP,
    output logic                      S_AXI_RVALID,
    input  wire logic                 S_AXI_RREADY
);
    import irq_resp_pkg::*;

    // Software-visible state.
    logic [1:0]      trig_type_q;
    logic [NSRC-1:0] enable_q;
    logic            global_en_q;
    logic [NSRC-1:0] prio_lo_q;
    logic [NSRC-1:0] prio_hi_q;
    logic [3:0]      int_stat_q;
    logic [3:0]      int_mask_q;
    logic [15:0]     last_vec_q;

    // Machine-cycle phase counter: twelve oscillator clocks per machine cycle.
    logic [3:0] phase_q;
    wire        state_five_phase_two = (phase_q == `PHASE_LATCH);
    wire        mc_end = (phase_q == 4'(`OSC_PER_MCYCLE - 1));
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) phase_q <= 4'h0;
        else       phase_q <= mc_end ? 4'h0 : phase_q + 4'h1;
    end
    assign PHASE = phase_q;

    // Two-flop synchronisers on the asynchronous request pins.
    logic [1:0] pin_meta_q;
    logic [1:0] pin_sync_q;
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pin_meta_q <= 2'b11;
            pin_sync_q <= 2'b11;
        end else begin
            pin_meta_q <= {EXT_IRQ1_PIN_N, EXT_IRQ0_PIN_N};
            pin_sync_q <= pin_meta_q;
        end
    end

    // Once-per-machine-cycle samples; only a change across samples counts as an edge,
    // which is why the source must hold each level for a full machine cycle.
    logic [1:0] pin_samp_q;
    logic [1:0] ext_flag_q;
    wire  [1:0] pin_low  = ~pin_sync_q;
    wire  [1:0] fall_det = pin_samp_q & ~pin_sync_q;
    logic [1:0] ext_clr;
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) pin_samp_q <= 2'b11;
        else if (state_five_phase_two) pin_samp_q <= pin_sync_q;
    end

    // Request flags: level mode follows the inverted pin, edge mode is sticky.
    // A falling edge latched in the same cycle as the vector-load clear wins.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ext
            always_ff @(posedge CLK or negedge RSTN) begin
                if (!RSTN) begin
                    ext_flag_q[gi] <= 1'b0;
                end else if (state_five_phase_two && !trig_type_q[gi]) begin
                    ext_flag_q[gi] <= pin_low[gi];
                end else if (state_five_phase_two && fall_det[gi]) begin
                    ext_flag_q[gi] <= 1'b1;
                end else if (ext_clr[gi]) begin
                    ext_flag_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Source requests; slot order gives the fixed tie-break within a level.
    wire [NSRC-1:0] req_raw;
    assign req_raw[`SRC_EXT0] = ext_flag_q[0];
    assign req_raw[`SRC_EXT1] = ext_flag_q[1];
    assign req_raw[`SRC_TMR0] = PERIPH_REQ[`SRC_TMR0];
    assign req_raw[`SRC_TMR1] = PERIPH_REQ[`SRC_TMR1];
    assign req_raw[`SRC_SER]  = PERIPH_REQ[`SRC_SER];
    assign req_raw[`SRC_TMR2] = PERIPH_REQ[`SRC_TMR2];

    // Poll snapshot taken at the end of each machine cycle; used in the next one.
    logic [NSRC-1:0] poll_q;
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN)       poll_q <= '0;
        else if (mc_end) poll_q <= req_raw & enable_q & {NSRC{global_en_q}};
    end

    // Highest-priority pending source, then blocking by in-progress levels.
    logic [3:0] active_q;
    logic       win_valid;
    logic [2:0] win_src;
    level_type  win_lvl;
    always_comb begin
        win_valid = 1'b0;
        win_src   = 3'd0;
        win_lvl   = 2'd0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (poll_q[i] && (!win_valid || {prio_hi_q[i], prio_lo_q[i]} >= win_lvl)) begin
                win_valid = 1'b1;
                win_src   = 3'(i);
                win_lvl   = {prio_hi_q[i], prio_lo_q[i]};
            end
        end
    end
    wire [3:0] level_ge_mask = 4'hf << win_lvl;
    wire       blocked       = |(active_q & level_ge_mask);

    // Extra-instruction rule: after return-from-interrupt or register access, one more must run.
    logic defer_q;
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) defer_q <= 1'b0;
        else if (INSTR_LAST_CYCLE && mc_end)
            defer_q <= INSTR_IS_RETURN_FROM_INTERRUPT || INSTR_IS_IRQ_REG_ACCESS;
    end

    // Acknowledge only at the end of an instruction's final machine cycle.
    logic           state_q;
    resp_state_type st_q;
    wire  ack = (st_q == ST_IDLE) && mc_end && INSTR_LAST_CYCLE && win_valid
                && !blocked && !defer_q && !INSTR_IS_RETURN_FROM_INTERRUPT
                && !INSTR_IS_IRQ_REG_ACCESS;

    // Vector-call sequencer: two machine cycles, low PC byte then high PC byte.
    logic [2:0]  call_src_q;
    logic [15:0] pc_save_q;
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_q       <= ST_IDLE;
            call_src_q <= 3'd0;
            pc_save_q  <= 16'h0000;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (ack) begin
                        st_q       <= ST_CALL1;
                        call_src_q <= win_src;
                        pc_save_q  <= PC_IN;
                    end
                end
                ST_CALL1: if (mc_end) st_q <= ST_CALL2;
                ST_CALL2: if (mc_end) st_q <= ST_IDLE;
                default:  st_q <= ST_IDLE;
            endcase
        end
    end
    assign CORE_HOLD = (st_q != ST_IDLE);
    assign state_q   = CORE_HOLD;

    // Stack traffic and program-counter load; status word is never pushed.
    wire       push_lo = (st_q == ST_CALL1) && mc_end;
    wire       push_hi = (st_q == ST_CALL2) && (phase_q == 4'h0);
    wire       vec_ld  = (st_q == ST_CALL2) && mc_end;
    wire [15:0] vec_addr = `VEC_BASE + (16'(call_src_q) * `VEC_STRIDE);
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            PUSH_VALID <= 1'b0;
            PUSH_DATA  <= 8'h00;
            PC_LOAD    <= 1'b0;
            PC_VECTOR  <= 16'h0000;
            POP_REQ    <= 1'b0;
        end else begin
            PUSH_VALID <= push_lo || push_hi;
            PUSH_DATA  <= push_lo ? pc_save_q[7:0] : pc_save_q[15:8];
            PC_LOAD    <= vec_ld;
            PC_VECTOR  <= vec_addr;
            POP_REQ    <= (INSTR_IS_RETURN_FROM_INTERRUPT || INSTR_IS_RET)
                          && INSTR_LAST_CYCLE && mc_end;
        end
    end

    // Edge flags cleared at the vector load that ends their call; serial flags are left alone.
    assign ext_clr[0] = vec_ld && (call_src_q == 3'(`SRC_EXT0)) && trig_type_q[0];
    assign ext_clr[1] = vec_ld && (call_src_q == 3'(`SRC_EXT1)) && trig_type_q[1];

    // In-progress bit per level; only return-from-interrupt clears the highest.
    wire return_done = INSTR_IS_RETURN_FROM_INTERRUPT && INSTR_LAST_CYCLE && mc_end;
    wire [3:0] hi_active = active_q[3] ? 4'h8 : active_q[2] ? 4'h4 :
                           active_q[1] ? 4'h2 : active_q[0] ? 4'h1 : 4'h0;
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) active_q <= 4'h0;
        else if (ack) active_q <= active_q | (4'h1 << win_lvl);
        else if (return_done) active_q <= active_q & ~hi_active;
    end

    // AXI4-Lite slave: one write and one read outstanding, address and data in any order.
    logic        aw_got_q;
    logic        w_got_q;
    logic [11:0] aw_addr_q;
    logic [31:0] w_data_q;
    assign S_AXI_AWREADY = !aw_got_q && !S_AXI_BVALID;
    assign S_AXI_WREADY  = !w_got_q && !S_AXI_BVALID;
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    wire wr_fire = aw_got_q && w_got_q && !S_AXI_BVALID;
    wire rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;
    wire wr_hit  = (aw_addr_q == `ADDR_CTRL) || (aw_addr_q == `ADDR_ENABLE) ||
                   (aw_addr_q == `ADDR_PRIO_LO) || (aw_addr_q == `ADDR_PRIO_HI) ||
                   (aw_addr_q == `ADDR_INT_MASK) || (aw_addr_q == `ADDR_STATUS) ||
                   (aw_addr_q == `ADDR_INT_STAT) || (aw_addr_q == `ADDR_VECTOR);
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            aw_addr_q    <= 12'h000;
            w_data_q     <= 32'h0000_0000;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= `RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_got_q  <= 1'b1;
                aw_addr_q <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_got_q  <= 1'b1;
                w_data_q <= S_AXI_WDATA;
            end
            if (wr_fire) begin
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // Register writes; only the low byte lane carries data, so only WSTRB[0] matters.
    wire w_data_ok = 1'b1;
    wire wr_en = wr_fire && w_data_ok;
    wire [3:0] wstrb_unused = S_AXI_WSTRB;
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            trig_type_q <= 2'b00;
            enable_q    <= '0;
            global_en_q <= 1'b0;
            prio_lo_q   <= '0;
            prio_hi_q   <= '0;
            int_mask_q  <= 4'h0;
        end else if (wr_en && wstrb_unused[0]) begin
            if (aw_addr_q == `ADDR_CTRL)     trig_type_q <= w_data_q[1:0];
            if (aw_addr_q == `ADDR_ENABLE) begin
                enable_q    <= w_data_q[NSRC-1:0];
                global_en_q <= w_data_q[7];
            end
            if (aw_addr_q == `ADDR_PRIO_LO)  prio_lo_q  <= w_data_q[NSRC-1:0];
            if (aw_addr_q == `ADDR_PRIO_HI)  prio_hi_q  <= w_data_q[NSRC-1:0];
            if (aw_addr_q == `ADDR_INT_MASK) int_mask_q <= w_data_q[3:0];
        end
    end

    // Sticky event bits: 0 acknowledge, 1 return-from-interrupt, 2/3 edge caught.
    // Clearing is by read; an event in the clearing cycle survives.
    wire [3:0] ev = {state_five_phase_two & fall_det[1] & trig_type_q[1],
                     state_five_phase_two & fall_det[0] & trig_type_q[0],
                     return_done, ack};
    wire       stat_rd = rd_fire && (S_AXI_ARADDR == `ADDR_INT_STAT);
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN)        int_stat_q <= 4'h0;
        else if (stat_rd) int_stat_q <= ev;
        else              int_stat_q <= int_stat_q | ev;
    end
    assign IRQ = |(int_stat_q & int_mask_q);

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN)       last_vec_q <= 16'h0000;
        else if (vec_ld) last_vec_q <= vec_addr;
    end

    // Read data mux.
    logic [31:0] rd_mux;
    always_comb begin
        case (S_AXI_ARADDR)
            `ADDR_CTRL:     rd_mux = {30'h0, trig_type_q};
            `ADDR_ENABLE:   rd_mux = {24'h0, global_en_q, 7'(enable_q)};
            `ADDR_PRIO_LO:  rd_mux = {26'h0, prio_lo_q};
            `ADDR_PRIO_HI:  rd_mux = {26'h0, prio_hi_q};
            `ADDR_STATUS:   rd_mux = {23'h0, state_q, active_q, ext_flag_q, defer_q, 1'b0};
            `ADDR_INT_STAT: rd_mux = {28'h0, int_stat_q};
            `ADDR_INT_MASK: rd_mux = {28'h0, int_mask_q};
            `ADDR_VECTOR:   rd_mux = {16'h0, last_vec_q};
            default:        rd_mux = 32'h0000_0000;
        endcase
    end
    wire rd_hit = (S_AXI_ARADDR[11:5] == 7'h00) && (S_AXI_ARADDR[1:0] == 2'b00);
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h0000_0000;
            S_AXI_RRESP  <= `RESP_OKAY;
        end else if (rd_fire) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA  <= rd_mux;
            S_AXI_RRESP  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> dv/irq_resp_chk.sv
// Concurrent checks on the ports of the interrupt response block.
`timescale 1ns/100ps
`default_nettype none
module irq_resp_chk (
    input  wire logic        CLK,
    input  wire logic        RSTN,
    input  wire logic [3:0]  PHASE,
    input  wire logic        CORE_HOLD,
    input  wire logic        PUSH_VALID,
    input  wire logic        PC_LOAD,
    input  wire logic [15:0] PC_VECTOR,
    input  wire logic        POP_REQ,
    input  wire logic        INSTR_IS_RETURN_FROM_INTERRUPT,
    input  wire logic        INSTR_IS_RET,
    input  wire logic        INSTR_LAST_CYCLE
);
    logic [5:0] hold_cnt_q;
    logic [5:0] hold_cnt_d;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // Counts the cycles of the current vector call so its span is checked exactly.
    assign hold_cnt_d = CORE_HOLD ? hold_cnt_q + 6'h01 : 6'h00;
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            hold_cnt_q <= 6'h00;
        end else begin
            hold_cnt_q <= hold_cnt_d;
        end
    end
    a_call_length: assert property ($fell(CORE_HOLD) |-> hold_cnt_q == 6'd24)
        else $error("vector call length wrong");
    a_call_bounded: assert property (hold_cnt_q <= 6'd24)
        else $error("vector call too long");
    a_ack_on_last: assert property ($rose(CORE_HOLD) |-> $past(PHASE) == 4'd11 && $past(INSTR_LAST_CYCLE))
        else $error("call began outside the last instruction cycle");
    a_call_pushes: assert property ($rose(CORE_HOLD) |-> ##[1:23] PUSH_VALID ##[1:12] PUSH_VALID)
        else $error("call did not push two bytes");
    a_push_in_call: assert property (PUSH_VALID |-> CORE_HOLD)
        else $error("push outside a vector call");
    a_vector_load: assert property ($rose(CORE_HOLD) |-> ##[20:30] PC_LOAD)
        else $error("vector not loaded after call");
    a_vector_table: assert property (PC_LOAD |-> PC_VECTOR[2:0] == 3'h3 && PC_VECTOR <= 16'h002b)
        else $error("vector outside the table");
    a_phase_wrap: assert property (PHASE == 4'd11 |=> PHASE == 4'd0)
        else $error("machine cycle did not wrap");
    a_phase_range: assert property (PHASE <= 4'd11)
        else $error("phase beyond machine cycle");
    a_pop_after_ret: assert property (POP_REQ |->
        $past(INSTR_IS_RETURN_FROM_INTERRUPT || INSTR_IS_RET))
        else $error("pop without a return");
    // Main scenarios: a call, a return and a vector to the second external source.
    cover property ($rose(CORE_HOLD));
    cover property (POP_REQ);
    cover property (PC_LOAD && PC_VECTOR == 16'h0013);
endmodule
bind irq_resp irq_resp_chk u_chk (.CLK(CLK), .RSTN(RSTN), .PHASE(PHASE), .CORE_HOLD(CORE_HOLD),
    .PUSH_VALID(PUSH_VALID), .PC_LOAD(PC_LOAD), .PC_VECTOR(PC_VECTOR), .POP_REQ(POP_REQ),
    .INSTR_IS_RETURN_FROM_INTERRUPT(INSTR_IS_RETURN_FROM_INTERRUPT),
    .INSTR_IS_RET(INSTR_IS_RET), .INSTR_LAST_CYCLE(INSTR_LAST_CYCLE));
`default_nettype wire

// >>> dv/core_model.sv
// Behavioural core that consumes vector calls and returns through its own stack.
`timescale 1ns/100ps
`default_nettype none
module core_model #(
    parameter logic [15:0] START_PC = 16'h1234
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        push_valid,
    input  wire logic [7:0]  push_data,
    input  wire logic        pop_req,
    input  wire logic        pc_load,
    input  wire logic [15:0] pc_vector,
    output logic [15:0]      pc_q
);
    logic [7:0] stack_q [0:15];
    logic [3:0] sp_q;
    // Low byte is pushed first, so a pop takes the high byte from the top; a swapped push
    // order in the block shows up as a wrong return address here.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pc_q <= START_PC;
            sp_q <= 4'h0;
        end else if (push_valid) begin
            stack_q[sp_q] <= push_data;
            sp_q <= sp_q + 4'h1;
        end else if (pop_req) begin
            pc_q <= {stack_q[sp_q - 4'h1], stack_q[sp_q - 4'h2]};
            sp_q <= sp_q - 4'h2;
        end else if (pc_load) begin
            pc_q <= pc_vector;
        end
    end
endmodule
`default_nettype wire

// >>> dv/irq_resp_bench.sv
// Self-checking bench for the four-level interrupt response block.
`timescale 1ns/100ps
`default_nettype none
module irq_resp_bench;
    logic        clk, rstn, pin0_n, pin1_n, is_return_from_interrupt, is_ret;
    logic        push_valid, pop_req, pc_load, is_reg;
    logic [5:0]  preq;
    logic        core_hold, irq, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp;
    logic [3:0]  phase;
    logic [7:0]  push_data;
    logic [11:0] awaddr, araddr;
    logic [15:0] pc, pc_vector;
    logic [31:0] wdata, rdata;
    int          compares, miscompares;
    irq_resp uut (.CLK(clk), .RSTN(rstn), .EXT_IRQ0_PIN_N(pin0_n), .EXT_IRQ1_PIN_N(pin1_n),
        .PERIPH_REQ(preq), .INSTR_LAST_CYCLE(1'b1),
        .INSTR_IS_RETURN_FROM_INTERRUPT(is_return_from_interrupt),
        .INSTR_IS_RET(is_ret), .INSTR_IS_IRQ_REG_ACCESS(is_reg), .PC_IN(pc),
        .PUSH_VALID(push_valid), .PUSH_DATA(push_data), .POP_REQ(pop_req), .PC_LOAD(pc_load),
        .PC_VECTOR(pc_vector), .CORE_HOLD(core_hold), .PHASE(phase), .IRQ(irq),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    core_model u_core (.clk(clk), .rstn(rstn), .push_valid(push_valid), .push_data(push_data),
        .pop_req(pop_req), .pc_load(pc_load), .pc_vector(pc_vector), .pc_q(pc));
    // 125 MHz clock.
    always #4 clk = ~clk;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic final_report();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Each channel is released only at the edge that takes it; one idle edge at the end
    // keeps back-to-back calls from assigning a valid twice in one time step.
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'b111;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
        @(posedge clk);
    endtask
    task automatic axi_rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk(rdata, e);
        chk({30'h0, rresp}, {30'h0, er});
        @(posedge clk);
    endtask
    // Waits for the vector load, then checks vector, latency and the core's new address.
    task automatic wait_load(input logic [15:0] ev);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!pc_load && n < 400);
        chk({16'h0, pc_vector}, {16'h0, ev});
        chk({31'h0, n > 36 && n < 108}, 32'h1);
        @(posedge clk);
        chk({16'h0, pc}, {16'h0, ev});
    endtask
    // Presents a one-machine-cycle return instruction, then lets the deferral pass.
    task automatic run_instr(input logic int_ret);
        do @(posedge clk); while (phase !== 4'd11);
        is_return_from_interrupt <= int_ret;
        is_ret <= !int_ret;
        repeat (12) @(posedge clk);
        {is_return_from_interrupt, is_ret} <= 2'b00;
        repeat (24) @(posedge clk);
    endtask
    task automatic t_regs();
        axi_rd(12'h000, 32'h0, 2'b00);
        axi_rd(12'h010, 32'h0, 2'b00);
        axi_rd(12'h020, 32'h0, 2'b10);
        axi_wr(12'h020, 32'h5a, 2'b10);
        axi_wr(12'h000, 32'h1, 2'b00);
        axi_rd(12'h000, 32'h1, 2'b00);
        axi_wr(12'h004, 32'h85, 2'b00);
        axi_wr(12'h018, 32'h1, 2'b00);
        chk({31'h0, irq}, 32'h0);
    endtask
    task automatic t_edge();
        pin0_n <= 1'b0;
        wait_load(16'h0003);
        chk({31'h0, irq}, 32'h1);
        axi_rd(12'h014, 32'h5, 2'b00);
        chk({31'h0, irq}, 32'h0);
        axi_rd(12'h010, 32'h10, 2'b00);
        pin0_n <= 1'b1;
        run_instr(1'b1);
        chk({16'h0, pc}, 32'h1234);
        axi_rd(12'h010, 32'h0, 2'b00);
    endtask
    // A serial request raised during an interrupt-register access must wait one more
    // instruction, so no call may start in the machine cycle right after the access.
    task automatic t_serial();
        logic quiet;
        axi_wr(12'h004, 32'h95, 2'b00);
        do @(posedge clk); while (phase !== 4'd11);
        preq[4] <= 1'b1;
        is_reg <= 1'b1;
        repeat (12) @(posedge clk);
        is_reg <= 1'b0;
        quiet = 1'b1;
        fork
            wait_load(16'h0023);
            begin
                repeat (13) begin
                    @(posedge clk);
                    if (core_hold !== 1'b0) quiet = 1'b0;
                end
            end
        join
        chk({31'h0, quiet}, 32'h1);
        preq[4] <= 1'b0;
        run_instr(1'b1);
        chk({16'h0, pc}, 32'h1234);
    endtask
    // Level source kept low past a plain return must stay blocked, while a higher level wins.
    task automatic t_prio();
        logic quiet;
        pin1_n <= 1'b0;
        wait_load(16'h0013);
        run_instr(1'b0);
        chk({16'h0, pc}, 32'h1234);
        quiet = 1'b1;
        repeat (48) begin
            @(posedge clk);
            if (core_hold !== 1'b0) quiet = 1'b0;
        end
        chk({31'h0, quiet}, 32'h1);
        axi_rd(12'h010, 32'h18, 2'b00);
        axi_wr(12'h00c, 32'h1, 2'b00);
        pin0_n <= 1'b0;
        wait_load(16'h0003);
        pin0_n <= 1'b1;
        axi_rd(12'h010, 32'h58, 2'b00);
        run_instr(1'b1);
        axi_rd(12'h010, 32'h18, 2'b00);
        pin1_n <= 1'b1;
        run_instr(1'b1);
        axi_rd(12'h010, 32'h0, 2'b00);
    endtask
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        {pin0_n, pin1_n} = 2'b11;
        {awvalid, wvalid, bready, arvalid, rready, is_return_from_interrupt, is_ret} = 7'h00;
        is_reg = 1'b0;
        preq = 6'h00;
        {awaddr, araddr, wdata} = 56'h0;
        compares = 0;
        miscompares = 0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_regs();
        t_edge();
        t_serial();
        t_prio();
        final_report();
    end
    // Watchdog: the full run needs a few thousand cycles at most.
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        final_report();
    end
endmodule
`default_nettype wire
